/* pciu_top.sv */
// Pin change interrupt unit: masks, group flags, vector requests and bus registers
// Contract
// - Group 2 requests on masked changes of inputs 23..16 when enabled globally.
// - Group 1 requests on a masked change of input 11 when enabled.
// - Group 0 requests on masked changes of inputs 3..0 when enabled.
// - A change on enabled pins sets the group flag; flag bit n is group n.
// - Flag, group enable and global enable all one request that group's vector.
// - Flag clears when the CPU starts that group's service.
// - Writing one clears a flag; writing zero leaves it.
// - Group 3 mask bits 3..0 enable inputs 27..24.
// - Group 2 mask bits 7..4 for 23..20, bits 2..0 for 18..16; bit 3 reserved.
// - Group 1 mask implements only bit 3 for input 11.
// - Group 0 mask bits 3..0 for inputs 3..0; upper bits read zero.
// - A cleared mask bit never contributes to flag or request.
// - Reserved bits read zero; masks and flags reset to zero.
// - Detection needs no separate I/O clock, so changes can wake the part; the code samples pins on clk, so detection needs that clock running.
// - Changes raise requests even when pins are driven as outputs.
// - Group 3 with global enable covers inputs 27..24 with its own vector.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pciu_cfg.svh"
module pciu_top import pciu_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PCIU_PINS-1:0] changeInputs,
    input wire logic globalIrqEnable,
    output logic [`PCIU_GROUPS-1:0] groupVector,
    output logic irq,
    input wire logic [`PCIU_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PCIU_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Registers
    // ****************************************
    pciu_byte_t groupChangeFlags;
    pciu_byte_t group0PinMask;
    pciu_byte_t group1PinMask;
    pciu_byte_t group2PinMask;
    pciu_byte_t group3PinMask;
    pciu_byte_t groupEnableReg;
    pciu_byte_t irqMask;
    logic [`PCIU_GROUPS-1:0] groupChanged;
    logic [`PCIU_GROUPS-1:0] serviceClear;
    logic wrStrobe;
    logic [7:0] wrIndex;
    logic [7:0] wrData;
    logic wrHit;
    logic [7:0] rdIndex;
    pciu_byte_t rdData;
    logic rdHit;

    function automatic logic isReg(input logic [7:0] idx);
        isReg = (idx == `PCIU_IDX_FLAGS) || (idx == `PCIU_IDX_MASK0) ||
                (idx == `PCIU_IDX_MASK1) || (idx == `PCIU_IDX_MASK2) ||
                (idx == `PCIU_IDX_MASK3) || (idx == `PCIU_IDX_ENABLE) ||
                (idx == `PCIU_IDX_IRQMASK) || (idx == `PCIU_IDX_SERVICE);
    endfunction

    function automatic logic wrTo(input logic [7:0] idx);
        wrTo = wrStrobe && (wrIndex == idx);
    endfunction

    assign wrHit = isReg(wrIndex);
    assign rdHit = isReg(rdIndex);

    pciu_axil_slave u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrStrobe(wrStrobe),
        .wrIndex(wrIndex),
        .wrData(wrData),
        .wrHit(wrHit),
        .rdIndex(rdIndex),
        .rdData(rdData),
        .rdHit(rdHit)
    );

    // ****************************************
    // Change detection per group
    // ****************************************
    // Pins are sampled raw, whatever their direction, so driving a pin as
    // an output still produces a change. The sample runs on the system clock.
    pciu_change_detect #(.WIDTH(4)) u_grp0 (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(changeInputs[3:0]),
        .pinMask(group0PinMask[3:0]),
        .changed(groupChanged[0])
    );

    pciu_change_detect #(.WIDTH(1)) u_grp1 (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(changeInputs[11:11]),
        .pinMask(group1PinMask[3:3]),
        .changed(groupChanged[1])
    );

    pciu_change_detect #(.WIDTH(8)) u_grp2 (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(changeInputs[23:16]),
        .pinMask(group2PinMask),
        .changed(groupChanged[2])
    );

    pciu_change_detect #(.WIDTH(4)) u_grp3 (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(changeInputs[27:24]),
        .pinMask(group3PinMask[3:0]),
        .changed(groupChanged[3])
    );

    // ****************************************
    // Mask and enable registers
    // ****************************************
    // Reserved bits are never stored, so they read back as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            group0PinMask <= `PCIU_RESET_VAL;
            group1PinMask <= `PCIU_RESET_VAL;
            group2PinMask <= `PCIU_RESET_VAL;
            group3PinMask <= `PCIU_RESET_VAL;
        end else begin
            if (wrTo(`PCIU_IDX_MASK0)) begin
                group0PinMask <= wrData & `PCIU_MASK0_BITS;
            end
            if (wrTo(`PCIU_IDX_MASK1)) begin
                group1PinMask <= wrData & `PCIU_MASK1_BITS;
            end
            if (wrTo(`PCIU_IDX_MASK2)) begin
                group2PinMask <= wrData & `PCIU_MASK2_BITS;
            end
            if (wrTo(`PCIU_IDX_MASK3)) begin
                group3PinMask <= wrData & `PCIU_MASK3_BITS;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            groupEnableReg <= `PCIU_RESET_VAL;
            irqMask <= `PCIU_RESET_VAL;
        end else begin
            if (wrTo(`PCIU_IDX_ENABLE)) begin
                groupEnableReg <= wrData & `PCIU_FLAG_BITS;
            end
            if (wrTo(`PCIU_IDX_IRQMASK)) begin
                irqMask <= wrData & `PCIU_FLAG_BITS;
            end
        end
    end

    // ****************************************
    // Group flags
    // ****************************************
    // Service entry is a write of ones to the service register, one per group
    assign serviceClear = wrTo(`PCIU_IDX_SERVICE) ? wrData[3:0] : 4'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            groupChangeFlags <= `PCIU_RESET_VAL;
        end else begin
            for (int g = 0; g < `PCIU_GROUPS; g++) begin
                if (groupChanged[g]) begin
                    groupChangeFlags[g] <= 1'b1;
                end else if (serviceClear[g] ||
                             (wrTo(`PCIU_IDX_FLAGS) && wrData[g])) begin
                    groupChangeFlags[g] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Requests and interrupt line
    // ****************************************
    always_comb begin
        groupVector = groupChangeFlags[3:0] & groupEnableReg[3:0] &
                      {`PCIU_GROUPS{globalIrqEnable}};
    end
    assign irq = |(groupChangeFlags[3:0] & irqMask[3:0]);

    // Read mux; unmapped words read zero with an error response
    always_comb begin
        case (rdIndex)
            `PCIU_IDX_FLAGS: rdData = groupChangeFlags;
            `PCIU_IDX_MASK0: rdData = group0PinMask;
            `PCIU_IDX_MASK1: rdData = group1PinMask;
            `PCIU_IDX_MASK2: rdData = group2PinMask;
            `PCIU_IDX_MASK3: rdData = group3PinMask;
            `PCIU_IDX_ENABLE: rdData = groupEnableReg;
            `PCIU_IDX_IRQMASK: rdData = irqMask;
            default: rdData = `PCIU_RESET_VAL;
        endcase
    end

    // ****************************************
    // Checks
    // ****************************************
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        groupChanged[2] |=> groupChangeFlags[2]) else $error("group 2 flag not set");
    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        (groupChanged[0] && wrTo(`PCIU_IDX_FLAGS) && wrData[0]) |=> groupChangeFlags[0])
        else $error("set lost to clear");
    w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!groupChanged[1] && wrTo(`PCIU_IDX_FLAGS) && wrData[1]) |=> !groupChangeFlags[1])
        else $error("flag not cleared");
    write_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (groupChangeFlags[3] && wrTo(`PCIU_IDX_FLAGS) && !wrData[3] && !serviceClear[3])
        |=> groupChangeFlags[3]) else $error("zero write cleared flag");
    service_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (serviceClear[2] && !groupChanged[2]) |=> !groupChangeFlags[2])
        else $error("service did not clear");
    vector_req_a: assert property (@(posedge clk) disable iff (!rst_n)
        groupVector[0] == (groupChangeFlags[0] && groupEnableReg[0] && globalIrqEnable))
        else $error("vector request wrong");
    masked_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        (group0PinMask[3:0] == 4'h0) |-> !groupChanged[0]) else $error("masked pin set flag");
    mask1_res_a: assert property (@(posedge clk) disable iff (!rst_n)
        (group1PinMask & ~`PCIU_MASK1_BITS) == 8'h00) else $error("mask1 reserved set");
    mask2_res_a: assert property (@(posedge clk) disable iff (!rst_n)
        !group2PinMask[3]) else $error("mask2 bit 3 set");
    change_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (group3PinMask[0] && $changed(changeInputs[24])) |=> groupChangeFlags[3])
        else $error("pin 24 change missed");
endmodule

/* pciu_cfg.svh */
// Register offsets, field layouts and reset values of the pin change interrupt unit
`ifndef PCIU_CFG_SVH
`define PCIU_CFG_SVH

// ****************************************
// Register indices; the byte address is four times the index
// ****************************************
`define PCIU_IDX_FLAGS 8'h3B
`define PCIU_IDX_MASK0 8'h6B
`define PCIU_IDX_MASK1 8'h6C
`define PCIU_IDX_MASK2 8'h6D
`define PCIU_IDX_MASK3 8'h73
`define PCIU_IDX_ENABLE 8'h68
`define PCIU_IDX_IRQMASK 8'h80
`define PCIU_IDX_SERVICE 8'h81
`define PCIU_ADDR_W 10

// ****************************************
// Field layouts and reset values
// ****************************************
`define PCIU_GROUPS 4
`define PCIU_PINS 28
`define PCIU_FLAG_BITS 8'h0F
`define PCIU_MASK0_BITS 8'h0F
`define PCIU_MASK1_BITS 8'h08
`define PCIU_MASK2_BITS 8'hF7
`define PCIU_MASK3_BITS 8'h0F
`define PCIU_RESET_VAL 8'h00
`define PCIU_RESP_OKAY 2'h0
`define PCIU_RESP_SLVERR 2'h2

`endif

/* pciu_pkg.sv */
// Types shared by the pin change interrupt unit
package pciu_pkg;
    typedef enum logic [1:0] {
        PCIU_RD_IDLE = 2'b00,
        PCIU_RD_RESP = 2'b01
    } pciu_rd_state_t;
    typedef logic [7:0] pciu_byte_t;
endpackage

/* pciu_change_detect.sv */
// Sampled change detector for one group of change inputs
`timescale 1ns/10ps
module pciu_change_detect import pciu_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] pinMask,
    output logic changed
);
    // Inputs are taken as synchronous, so one sample stage suffices
    logic [WIDTH-1:0] lastSample;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastSample <= '0;
        end else begin
            lastSample <= pinIn;
        end
    end

    // Masked difference ORed; a cleared mask bit never contributes
    always_comb begin
        changed = |((pinIn ^ lastSample) & pinMask);
    end
endmodule

/* pciu_axil_slave.sv */
// AXI4-Lite slave front end: decodes writes into single-cycle strobes and reads into a register index
`timescale 1ns/10ps
`include "pciu_cfg.svh"
module pciu_axil_slave import pciu_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PCIU_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`PCIU_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrStrobe,
    output logic [7:0] wrIndex,
    output logic [7:0] wrData,
    input wire logic wrHit,
    output logic [7:0] rdIndex,
    input wire logic [7:0] rdData,
    input wire logic rdHit
);
    logic awHeld;
    logic wHeld;
    logic [7:0] awIndex;
    logic [7:0] wByte;
    logic wLane0;
    pciu_rd_state_t rdState;

    // Address and data taken in either order, held until both are in
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = (rdState == PCIU_RD_IDLE);
    assign rdIndex = s_axi_araddr[`PCIU_ADDR_W-1:2];
    assign wrIndex = awIndex;
    assign wrData = wByte;
    assign wrStrobe = awHeld && wHeld && wLane0 && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            awIndex <= `PCIU_RESET_VAL;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awIndex <= s_axi_awaddr[`PCIU_ADDR_W-1:2];
        end else if (awHeld && wHeld) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld <= 1'b0;
            wByte <= `PCIU_RESET_VAL;
            wLane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLane0 <= s_axi_wstrb[0];
        end else if (awHeld && wHeld) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCIU_RESP_OKAY;
        end else if (awHeld && wHeld && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `PCIU_RESP_OKAY : `PCIU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read data captured at the address handshake, upper bits zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdState <= PCIU_RD_IDLE;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PCIU_RESP_OKAY;
        end else begin
            case (rdState)
                PCIU_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState <= PCIU_RD_RESP;
                        s_axi_rdata <= {24'h000000, rdData};
                        s_axi_rresp <= rdHit ? `PCIU_RESP_OKAY : `PCIU_RESP_SLVERR;
                    end
                end
                PCIU_RD_RESP: begin
                    if (s_axi_rready) begin
                        rdState <= PCIU_RD_IDLE;
                    end
                end
                default: begin
                    rdState <= PCIU_RD_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rdState == PCIU_RD_RESP);
endmodule

/* pciu_pin_model.sv */
// Far-side model: external change pins and the CPU's vector dispatch
`timescale 1ns/10ps
`include "pciu_cfg.svh"
module pciu_pin_model import pciu_pkg::*; (
    input wire logic clk,
    input wire logic [`PCIU_GROUPS-1:0] groupVector,
    output logic [`PCIU_PINS-1:0] changeInputs,
    output logic globalIrqEnable,
    output logic [1:0] dispGroup,
    output logic dispValid
);
    initial begin
        changeInputs = 28'h0000000;
        globalIrqEnable = 1'b0;
    end

    // Pins toggled by software as outputs still count as changes
    task automatic toggle(input logic [`PCIU_PINS-1:0] pins);
        @(posedge clk);
        changeInputs <= changeInputs ^ pins;
    endtask

    task automatic set_global(input logic en);
        @(posedge clk);
        globalIrqEnable <= en;
    endtask

    // Lowest group wins, as a fixed-priority vector table would
    always_comb begin
        dispValid = |groupVector;
        dispGroup = 2'h0;
        for (int g = 3; g >= 0; g--) begin
            if (groupVector[g]) begin
                dispGroup = g[1:0];
            end
        end
    end
endmodule

/* pciu_tb_top.sv */
// Self-checking testbench for the pin change interrupt unit
`timescale 1ns/10ps
`include "pciu_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failCount++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module pciu_tb_top import pciu_pkg::*; ;
    localparam logic [9:0] aFlg = {`PCIU_IDX_FLAGS, 2'b00};
    localparam logic [9:0] aEn = {`PCIU_IDX_ENABLE, 2'b00};
    localparam logic [9:0] aIrqM = {`PCIU_IDX_IRQMASK, 2'b00};
    localparam logic [9:0] aSvc = {`PCIU_IDX_SERVICE, 2'b00};
    localparam logic [9:0] maskAddr [4] = '{{`PCIU_IDX_MASK0, 2'b00},
        {`PCIU_IDX_MASK1, 2'b00}, {`PCIU_IDX_MASK2, 2'b00}, {`PCIU_IDX_MASK3, 2'b00}};
    localparam logic [7:0] maskBits [4] = '{`PCIU_MASK0_BITS, `PCIU_MASK1_BITS,
        `PCIU_MASK2_BITS, `PCIU_MASK3_BITS};
    localparam logic [27:0] grpPins [4] = '{28'h000000F, 28'h0000800, 28'h0810000,
        28'hF000000};
    localparam logic [1:0] OK = `PCIU_RESP_OKAY;
    localparam logic [1:0] ERR = `PCIU_RESP_SLVERR;
    logic clk;
    logic rst_n;
    logic [9:0] awaddr;
    logic [9:0] araddr;
    logic awvalid;
    logic wvalid;
    logic bready;
    logic arvalid;
    logic rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic irq;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] groupVector;
    logic [27:0] changeInputs;
    logic globalIrqEnable;
    logic [1:0] dispGroup;
    logic dispValid;
    int failCount;
    int checked;

    pciu_top uut (.clk(clk), .rst_n(rst_n), .changeInputs(changeInputs),
        .globalIrqEnable(globalIrqEnable), .groupVector(groupVector), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pciu_pin_model pins (.clk(clk), .groupVector(groupVector), .changeInputs(changeInputs),
        .globalIrqEnable(globalIrqEnable), .dispGroup(dispGroup), .dispValid(dispValid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                `CHK(bresp, er)
            end
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                rready <= 1'b0;
                `CHK(rdata, {24'h000000, e})
                `CHK(rresp, er)
            end
        end
    endtask

    // Flag lands one edge after the change; three edges leave margin
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        `CHK(groupVector, 4'h0)
        rd(aFlg, 8'h00, OK);
        for (int i = 0; i < 4; i++) begin
            rd(maskAddr[i], 8'h00, OK);
            wr(maskAddr[i], 8'hFF, OK);
            rd(maskAddr[i], maskBits[i], OK);
        end
        rd(10'h3F0, 8'h00, ERR);
        wr(10'h3F0, 8'hFF, ERR);
        // Byte lane 0 off: the write is answered but changes nothing
        wstrb <= 4'hE;
        wr(maskAddr[0], 8'h00, OK);
        wstrb <= 4'hF;
        rd(maskAddr[0], `PCIU_MASK0_BITS, OK);
    endtask

    task automatic t_groups;
        pins.set_global(1'b1);
        for (int g = 0; g < 4; g++) begin
            wr(aEn, 8'h01 << g, OK);
            pins.toggle(grpPins[g]);
            settle();
            `CHK(groupVector, 4'h1 << g)
            `CHK(dispGroup, 2'(g))
            rd(aFlg, 8'h01 << g, OK);
            wr(aFlg, 8'h00, OK);
            rd(aFlg, 8'h01 << g, OK);
            wr(aFlg, 8'h01 << g, OK);
            rd(aFlg, 8'h00, OK);
        end
    endtask

    task automatic t_masked;
        wr(aEn, 8'h0F, OK);
        pins.toggle(28'h008F7F0);
        settle();
        rd(aFlg, 8'h00, OK);
        wr(maskAddr[0], 8'h00, OK);
        pins.toggle(28'h000000F);
        settle();
        rd(aFlg, 8'h00, OK);
        `CHK(groupVector, 4'h0)
        wr(maskAddr[0], 8'hFF, OK);
    endtask

    task automatic t_service;
        pins.set_global(1'b0);
        pins.toggle(28'h0000001);
        settle();
        `CHK(groupVector, 4'h0)
        rd(aFlg, 8'h01, OK);
        pins.set_global(1'b1);
        settle();
        `CHK(groupVector, 4'h1)
        `CHK(dispValid, 1'b1)
        wr(aSvc, 8'h01 << dispGroup, OK);
        `CHK(groupVector, 4'h0)
        `CHK(dispValid, 1'b0)
        rd(aFlg, 8'h00, OK);
        rd(aSvc, 8'h00, OK);
    endtask

    task automatic t_irq;
        wr(aIrqM, 8'h01, OK);
        pins.toggle(28'h0000002);
        settle();
        `CHK(irq, 1'b1)
        wr(aIrqM, 8'h00, OK);
        `CHK(irq, 1'b0)
        wr(aIrqM, 8'h01, OK);
        `CHK(irq, 1'b1)
        wr(aFlg, 8'h01, OK);
        `CHK(irq, 1'b0)
    endtask

    // Clear and a fresh change hit the flag on the same edge
    task automatic t_race;
        pins.toggle(28'h0000001);
        settle();
        fork
            wr(aFlg, 8'h01, OK);
            begin
                @(posedge clk);
                pins.toggle(28'h0000001);
            end
        join
        rd(aFlg, 8'h01, OK);
        wr(aFlg, 8'h01, OK);
        rd(aFlg, 8'h00, OK);
    endtask

    // Reset in mid-run returns flags, masks and enables to zero
    task automatic t_reset;
        pins.toggle(28'h0000001);
        settle();
        rd(aFlg, 8'h01, OK);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(groupVector, 4'h0)
        rd(aFlg, 8'h00, OK);
        rd(maskAddr[0], 8'h00, OK);
        rd(aEn, 8'h00, OK);
    endtask

    task automatic end_of_test;
        if (failCount == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        failCount = 0;
        checked = 0;
        rst_n = 1'b0;
        awaddr = 10'h000;
        araddr = 10'h000;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_groups();
        t_masked();
        t_service();
        t_irq();
        t_race();
        t_reset();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        end_of_test();
    end
endmodule
